// File: rtl/cledh_host.sv
// How it works
// - Header starts with sync byte E8.
// - Two command bits sent three times.
// - Host sends fault tally as zero.
// - Trim two bytes; global, config doubled.
// - First-bank trim byte before second-bank.
// - Global intensity byte sent twice.
// - Configuration byte sent twice per driver.
// - PWM outputs descending, words MSB first.
// - Multiplex sends two interleaved words each.
// - Optional tail returns to host.
// - One data set per driver, nearest first.
//
// Decided for this implementation: the register offsets and register access over Wishbone.
`include "cledh_defs.svh"

module cledh_host #(
    parameter int PWM_W    = 14,
    parameter int HALF_DIV = 2,
    parameter int MEM_AW   = 9
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [5:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Link to the first driver
    output logic             serial_clock_out,
    output logic             serial_data_out,
    output logic             frame_strobe_out,
    // Return from the last driver
    input  wire logic        return_clock_in,
    input  wire logic        return_data_in
);
    import cledh_pkg::*;

    if (!(PWM_W == 12 || PWM_W == 14)) begin : g_chk_w
        $error("PWM_W must be 12 or 14");
    end
    if (HALF_DIV < 2 || MEM_AW < 5 || MEM_AW > 14) begin : g_chk_p
        $error("HALF_DIV or MEM_AW out of range");
    end

    localparam logic [15:0] PWM_PAD = 16'((1 << (`CLEDH_WORD_W - PWM_W)) - 1);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers.

    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  sel);
        logic [31:0] m;
        m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
        return (old_v & ~m) | (new_v & m);
    endfunction

    function automatic logic [5:0] words_per_dev(input logic [1:0] cmd, input logic mux);
        if (cmd == CMD_PWM) return mux ? `CLEDH_WPD_MUX : `CLEDH_WPD_PLAIN;
        return `CLEDH_WPD_BYTE;
    endfunction

    function automatic logic [15:0] fmt_word(input logic [1:0] cmd, input logic [15:0] w);
        unique case (cmd)
            CMD_PWM:    return 16'(w << (`CLEDH_WORD_W - PWM_W));
            CMD_TRIM:   return w;
            CMD_GLOBAL: return {w[7:0], w[7:0]};
            CMD_CONFIG: return {w[7:0], w[7:0]};
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Submodules.

    cledh_link_if lk();

    cledh_clkgen #(.HALF_DIV(HALF_DIV)) u_clkgen (
        .clock      (clock),
        .rst_n      (rst_n),
        .link_clock (serial_clock_out),
        .lk         (lk.clk)
    );

    cledh_rx u_rx (
        .clock         (clock),
        .rst_n         (rst_n),
        .ret_clock_pin (return_clock_in),
        .ret_data_pin  (return_data_in),
        .lk            (lk.rx)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register file.

    cledh_tx_t          st_r;
    logic [1:0]         cmd_r;
    logic               mux_r;
    logic [7:0]         ndev_r;
    logic [5:0]         tail_len_r;
    logic [31:0]        tail_pat_r;
    logic [MEM_AW-1:0]  wr_ptr_r;
    logic               done_r, tok_r, err_r, ack_r;
    logic [9:0]         tally_r;
    logic [5:0]         echo_r;
    logic [31:0]        dat_r;
    logic [15:0]        mem [2**MEM_AW];

    logic        acc, wr_go, idle, go, too_big, launch;
    logic [31:0] ctrl_old, ctrl_wr, rd_mux, tlen_wr;
    logic [13:0] total_new;
    logic [1:0]  new_cmd;

    assign acc       = wb_cyc_i & wb_stb_i;
    assign wr_go     = acc & ack_r & wb_we_i;
    assign idle      = (st_r == TX_IDLE);
    assign ctrl_old  = {16'h0000, ndev_r, 4'h0, mux_r, cmd_r, 1'b0};
    assign ctrl_wr   = merge(ctrl_old, wb_dat_i, wb_sel_i);
    assign tlen_wr   = merge({26'h0, tail_len_r}, wb_dat_i, wb_sel_i);
    assign new_cmd   = ctrl_wr[2:1];
    assign total_new = 14'(ctrl_wr[15:8]) * 14'(words_per_dev(new_cmd, ctrl_wr[`CLEDH_CTRL_MUX]));
    assign too_big   = (15'(total_new) > 15'(2**MEM_AW));
    assign go        = wr_go & idle & (wb_adr_i == `CLEDH_OFS_CTRL) & ctrl_wr[`CLEDH_CTRL_GO];
    assign launch    = go & ~too_big;
    assign wb_ack_o  = ack_r;
    assign wb_dat_o  = dat_r;

    assign rd_mux = (wb_adr_i == `CLEDH_OFS_CTRL)    ? ctrl_old :
                    (wb_adr_i == `CLEDH_OFS_TAILLEN) ? {26'h0, tail_len_r} :
                    (wb_adr_i == `CLEDH_OFS_TAILPAT) ? tail_pat_r :
                    (wb_adr_i == `CLEDH_OFS_STAT)    ? {6'h00, tally_r, 2'b00, echo_r,
                                                        3'b000, err_r, 1'b0, tok_r,
                                                        done_r, ~idle} :
                    (wb_adr_i == `CLEDH_OFS_MADR)    ? 32'(wr_ptr_r) : 32'h0000_0000;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ack_r <= 1'b0;
            dat_r <= 32'h0000_0000;
        end else begin
            ack_r <= acc & ~ack_r;
            dat_r <= (acc & ~ack_r) ? rd_mux : dat_r;
        end
    end

    // Settings and the memory pointer change only between frames.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmd_r <= CMD_PWM;
            mux_r <= 1'b0;
            ndev_r <= `CLEDH_NDEV_RST;
            tail_len_r <= 6'h00;
            tail_pat_r <= 32'h0000_0000;
            wr_ptr_r <= '0;
        end else if (wr_go & idle) begin
            if (wb_adr_i == `CLEDH_OFS_CTRL) begin
                {ndev_r, mux_r, cmd_r} <= {ctrl_wr[15:8], ctrl_wr[3:1]};
            end
            if (wb_adr_i == `CLEDH_OFS_TAILLEN) begin
                tail_len_r <= (tlen_wr[5:0] > `CLEDH_TAIL_MAX) ? `CLEDH_TAIL_MAX : tlen_wr[5:0];
            end
            if (wb_adr_i == `CLEDH_OFS_TAILPAT) tail_pat_r <= merge(tail_pat_r, wb_dat_i, wb_sel_i);
            if (wb_adr_i == `CLEDH_OFS_MADR) wr_ptr_r <= wb_dat_i[MEM_AW-1:0];
            if (wb_adr_i == `CLEDH_OFS_MDAT) wr_ptr_r <= wr_ptr_r + 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (wr_go & idle & (wb_adr_i == `CLEDH_OFS_MDAT)) mem[wr_ptr_r] <= wb_dat_i[15:0];
    end

    // Result flags; a result arriving with a new start is kept.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {done_r, tok_r, err_r} <= 3'b000;
            tally_r <= 10'h000;
            echo_r <= 6'h00;
        end else begin
            done_r <= lk.done | (done_r & ~launch);
            err_r <= (go & too_big) | (err_r & ~launch);
            if (lk.done) begin
                tok_r <= lk.tail_ok;
                tally_r <= lk.tally;
                echo_r <= lk.cmd_echo;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame transmitter.

    logic [23:0]       hdr_sr_r;
    logic [15:0]       word_sr_r, mem_q;
    logic [4:0]        cnt_r;
    logic [13:0]       wcnt_r, total_r;
    logic [5:0]        tcnt_r, tidx;
    logic [MEM_AW-1:0] rd_ptr_r;
    logic              dout_r, strobe_r;
    logic              tick, hdr_last, word_last, data_done, tail_end, load_w;
    logic [4:0]        wbits_last;
    logic [23:0]       hdr_val;

    assign tick       = lk.fall_en;
    assign hdr_val    = {`CLEDH_SYNC, {`CLEDH_CMD_REP{new_cmd}}, {`CLEDH_TALLY_W{1'b0}}};
    assign wbits_last = (cmd_r == CMD_PWM) ? 5'(PWM_W - 1) : 5'(`CLEDH_WORD_W - 1);
    assign hdr_last   = (st_r == TX_HDR) & (cnt_r == `CLEDH_HDR_LAST);
    assign word_last  = (st_r == TX_DATA) & (cnt_r == wbits_last);
    assign data_done  = word_last & (wcnt_r == total_r - 14'd1);
    assign tail_end   = (st_r == TX_TAIL) & (tcnt_r == tail_len_r);
    assign load_w     = tick & ((hdr_last & (total_r != 14'd0)) | (word_last & ~data_done));
    assign tidx       = 6'(tail_len_r - 6'd1 - tcnt_r);
    assign lk.arm      = launch;
    assign lk.tail_len = tail_len_r;
    assign lk.tail_pat = tail_pat_r;
    assign serial_data_out  = dout_r;
    assign frame_strobe_out = strobe_r;

    always_ff @(posedge clock) mem_q <= mem[rd_ptr_r];

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= TX_IDLE;
            total_r <= 14'd0;
        end else if (launch) begin
            st_r <= TX_HDR;
            total_r <= total_new;
        end else if (tick) begin
            unique case (st_r)
                TX_IDLE: ;
                TX_HDR:  if (hdr_last) st_r <= (total_r == 14'd0) ? TX_TAIL : TX_DATA;
                TX_DATA: if (data_done) st_r <= TX_TAIL;
                TX_TAIL: if (tail_end) st_r <= TX_GAP;
                TX_GAP:  if (cnt_r == `CLEDH_GAP_BITS) st_r <= TX_IDLE;
                default: st_r <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 5'd0;
            tcnt_r <= 6'd0;
        end else if (launch) begin
            cnt_r <= 5'd0;
            tcnt_r <= 6'd0;
        end else if (tick) begin
            cnt_r <= (hdr_last | word_last | st_r == TX_TAIL) ? 5'd0 : cnt_r + 5'd1;
            tcnt_r <= (st_r == TX_TAIL & ~tail_end) ? tcnt_r + 6'd1 : tcnt_r;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hdr_sr_r <= 24'h000000;
            word_sr_r <= 16'h0000;
            rd_ptr_r <= '0;
            wcnt_r <= 14'd0;
        end else if (launch) begin
            hdr_sr_r <= hdr_val;
            rd_ptr_r <= '0;
            wcnt_r <= 14'd0;
        end else if (load_w) begin
            word_sr_r <= fmt_word(cmd_r, mem_q);
            rd_ptr_r <= rd_ptr_r + 1'b1;
            wcnt_r <= (st_r == TX_DATA) ? wcnt_r + 14'd1 : 14'd0;
        end else if (tick) begin
            hdr_sr_r <= (st_r == TX_HDR) ? {hdr_sr_r[22:0], 1'b0} : hdr_sr_r;
            word_sr_r <= (st_r == TX_DATA) ? {word_sr_r[14:0], 1'b0} : word_sr_r;
        end
    end

    // Bits change with the falling link clock so drivers sample mid-bit.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            dout_r <= 1'b0;
            strobe_r <= 1'b0;
        end else if (tick) begin
            unique case (st_r)
                TX_HDR:  dout_r <= hdr_sr_r[23];
                TX_DATA: dout_r <= word_sr_r[15];
                TX_TAIL: dout_r <= tail_end ? 1'b0 : tail_pat_r[tidx[4:0]];
                default: dout_r <= 1'b0;
            endcase
            if (st_r == TX_HDR && cnt_r == `CLEDH_STROBE_IDX) strobe_r <= 1'b1;
            if (tail_end) strobe_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    logic [19:0] dbits_r;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) dbits_r <= 20'd0;
        else if (launch) dbits_r <= 20'd0;
        else if (tick && st_r == TX_DATA) dbits_r <= dbits_r + 20'd1;
    end

    sync_field_a: assert property (@(posedge clock) disable iff (!rst_n)
        launch |=> hdr_sr_r[23:16] == `CLEDH_SYNC)
        else $error("sync byte wrong");
    cmd_triple_a: assert property (@(posedge clock) disable iff (!rst_n)
        launch |=> hdr_sr_r[15:10] == {cmd_r, cmd_r, cmd_r})
        else $error("command not tripled");
    tally_zero_a: assert property (@(posedge clock) disable iff (!rst_n)
        launch |=> hdr_sr_r[9:0] == 10'h000)
        else $error("tally not zero");
    strobe_rise_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(strobe_r) |-> st_r == TX_HDR && cnt_r == `CLEDH_STROBE_IDX + 5'd1)
        else $error("strobe rose at wrong bit");
    strobe_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
        st_r == TX_IDLE |-> !strobe_r)
        else $error("strobe high between frames");
    byte_twice_a: assert property (@(posedge clock) disable iff (!rst_n)
        load_w && cmd_r[1] |=> word_sr_r[15:8] == word_sr_r[7:0])
        else $error("byte not doubled");
    trim_order_a: assert property (@(posedge clock) disable iff (!rst_n)
        load_w && cmd_r == CMD_TRIM |=> word_sr_r == $past(mem_q))
        else $error("trim bytes reordered");
    pwm_pad_a: assert property (@(posedge clock) disable iff (!rst_n)
        load_w && cmd_r == CMD_PWM |=> (word_sr_r & PWM_PAD) == 16'h0000)
        else $error("pwm word misaligned");
    data_len_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(st_r == TX_TAIL) |-> dbits_r == 20'(total_r) * 20'(wbits_last + 5'd1))
        else $error("data length wrong");
    mux_len_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(st_r == TX_TAIL) && cmd_r == CMD_PWM |-> total_r == 14'(ndev_r) *
            14'(mux_r ? `CLEDH_WPD_MUX : `CLEDH_WPD_PLAIN))
        else $error("pwm word count wrong");
    tail_len_a: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(st_r == TX_GAP) |-> tcnt_r == tail_len_r && !strobe_r)
        else $error("tail length wrong");

    frame_start_c: cover property (@(posedge clock) disable iff (!rst_n) launch);
    mux_frame_c:   cover property (@(posedge clock) disable iff (!rst_n)
        $rose(st_r == TX_TAIL) && cmd_r == CMD_PWM && mux_r);
    result_ok_c:   cover property (@(posedge clock) disable iff (!rst_n) lk.done && lk.tail_ok);
endmodule // cledh_host

// File: rtl/cledh_defs.svh
`ifndef CLEDH_DEFS_SVH
`define CLEDH_DEFS_SVH

// Frame layout.
`define CLEDH_SYNC         8'hE8
`define CLEDH_CMD_REP      3
`define CLEDH_TALLY_W      10
`define CLEDH_WORD_W       16
`define CLEDH_STROBE_IDX   5'd8
`define CLEDH_HDR_LAST     5'd23
`define CLEDH_RX_HDR_LAST  5'd15
`define CLEDH_GAP_BITS     5'd8
`define CLEDH_WPD_PLAIN    6'd16
`define CLEDH_WPD_MUX      6'd32
`define CLEDH_WPD_BYTE     6'd1
`define CLEDH_TAIL_MAX     6'd32

// Register offsets.
`define CLEDH_OFS_CTRL     6'h00
`define CLEDH_OFS_TAILLEN  6'h04
`define CLEDH_OFS_TAILPAT  6'h08
`define CLEDH_OFS_STAT     6'h0C
`define CLEDH_OFS_MADR     6'h10
`define CLEDH_OFS_MDAT     6'h14

// Control fields.
`define CLEDH_CTRL_GO      0
`define CLEDH_CTRL_MUX     3
`define CLEDH_NDEV_RST     8'h01

`endif

// File: rtl/cledh_pkg.sv
package cledh_pkg;
    typedef enum logic [2:0] {
        TX_IDLE = 3'b000,
        TX_HDR  = 3'b001,
        TX_DATA = 3'b011,
        TX_TAIL = 3'b010,
        TX_GAP  = 3'b110
    } cledh_tx_t;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_HUNT = 2'b01,
        RX_HDR  = 2'b11,
        RX_TAIL = 2'b10
    } cledh_rx_t;
    typedef enum logic [1:0] {
        CMD_PWM    = 2'b00,
        CMD_TRIM   = 2'b01,
        CMD_GLOBAL = 2'b10,
        CMD_CONFIG = 2'b11
    } cledh_cmd_t;
endpackage

// File: rtl/cledh_link_if.sv
interface cledh_link_if;
    logic        fall_en;
    logic        arm;
    logic [5:0]  tail_len;
    logic [31:0] tail_pat;
    logic        done;
    logic        tail_ok;
    logic [9:0]  tally;
    logic [5:0]  cmd_echo;
    modport clk  (output fall_en);
    modport host (input fall_en, output arm, tail_len, tail_pat,
                  input done, tail_ok, tally, cmd_echo);
    modport rx   (input arm, tail_len, tail_pat, output done, tail_ok, tally, cmd_echo);
endinterface

// File: rtl/cledh_clkgen.sv
module cledh_clkgen #(
    parameter int HALF_DIV = 2
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // Link clock pin
    output logic      link_clock,
    // Bit timing
    cledh_link_if.clk lk
);
    logic [15:0] div_r;
    logic        clk_r;
    logic        wrap;

    assign wrap       = (div_r == 16'(HALF_DIV - 1));
    assign link_clock = clk_r;
    assign lk.fall_en = wrap & clk_r;

    // The link clock runs freely so the drivers always see edges.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 16'h0000;
            clk_r <= 1'b0;
        end else begin
            div_r <= wrap ? 16'h0000 : div_r + 16'h0001;
            clk_r <= wrap ? ~clk_r : clk_r;
        end
    end
endmodule // cledh_clkgen

// File: rtl/cledh_rx.sv
`include "cledh_defs.svh"

module cledh_rx (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // Return pins from the last driver
    input  wire logic ret_clock_pin,
    input  wire logic ret_data_pin,
    // Result
    cledh_link_if.rx  lk
);
    import cledh_pkg::*;

    logic      rc_s1, rc_s2, rc_s3, rd_s1, rd_s2;
    cledh_rx_t st_r;
    logic [7:0]  hunt_r;
    logic [15:0] hdr_r;
    logic [5:0]  cnt_r;
    logic        rise, hit, tail_end, ok_bit;
    logic [5:0]  tidx;

    assign rise     = rc_s2 & ~rc_s3;
    assign hit      = ({hunt_r[6:0], rd_s2} == `CLEDH_SYNC);
    assign tidx     = 6'(lk.tail_len - 6'd1 - cnt_r);
    assign ok_bit   = (rd_s2 == lk.tail_pat[tidx[4:0]]);
    assign tail_end = (cnt_r == 6'(lk.tail_len - 6'd1));

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {rc_s1, rc_s2, rc_s3, rd_s1, rd_s2} <= 5'h00;
        end else begin
            {rc_s1, rc_s2, rc_s3} <= {ret_clock_pin, rc_s1, rc_s2};
            {rd_s1, rd_s2}        <= {ret_data_pin, rd_s1};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= RX_IDLE;
            hunt_r <= 8'h00;
            hdr_r <= 16'h0000;
            cnt_r <= 6'h00;
            lk.done <= 1'b0;
            lk.tail_ok <= 1'b0;
            lk.tally <= 10'h000;
            lk.cmd_echo <= 6'h00;
        end else begin
            lk.done <= 1'b0;
            if (lk.arm) begin
                st_r <= RX_HUNT;
                hunt_r <= 8'h00;
                lk.tail_ok <= 1'b1;
            end else if (rise) begin
                unique case (st_r)
                    RX_IDLE: ;
                    RX_HUNT: begin
                        hunt_r <= {hunt_r[6:0], rd_s2};
                        cnt_r <= 6'h00;
                        if (hit) st_r <= RX_HDR;
                    end
                    RX_HDR: begin
                        hdr_r <= {hdr_r[14:0], rd_s2};
                        cnt_r <= cnt_r + 6'h01;
                        if (cnt_r == 6'(`CLEDH_RX_HDR_LAST)) begin
                            lk.tally <= {hdr_r[8:0], rd_s2};
                            lk.cmd_echo <= hdr_r[14:9];
                            cnt_r <= 6'h00;
                            st_r <= (lk.tail_len == 6'h00) ? RX_IDLE : RX_TAIL;
                            lk.done <= (lk.tail_len == 6'h00);
                        end
                    end
                    RX_TAIL: begin
                        lk.tail_ok <= lk.tail_ok & ok_bit;
                        cnt_r <= cnt_r + 6'h01;
                        if (tail_end) begin
                            st_r <= RX_IDLE;
                            lk.done <= 1'b1;
                        end
                    end
                endcase
            end
        end
    end
endmodule // cledh_rx

// File: testbench/cledh_drv_model.sv
module cledh_drv_model #(
    parameter int W = 14
) (
    // Link from the host
    input  wire logic         lclk,
    input  wire logic         din,
    input  wire logic         strb,
    // Settings of the driver
    input  wire logic         fault,
    input  wire logic         mux,
    // Return to the host
    output logic              rclk,
    output logic              rdat,
    // Captured set and header
    output logic [447:0]      got,
    output logic [5:0]        c,
    output logic [9:0]        t
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [23:0] sh  = 24'h000000;
    logic [23:0] hdr = 24'h000000;
    logic        rc  = 1'b0;
    logic        act = 1'b0;
    int          st  = 0;
    int          n   = 0;
    int          len = 16;
    bit          q[$];
    initial rdat = 1'b0;
    assign rclk = rc & act;
    always #100 rc = ~rc;
    always @(posedge lclk) begin
        sh = {sh[22:0], din};
        if (st == 0 && !strb && sh[7:0] == 8'hE8) begin
            st = 1;
            n = 0;
        end else if (st == 1) begin
            n = n + 1;
            if (n == 16) begin
                c = sh[15:10];
                t = sh[9:0];
                len = (c[1:0] == 2'b00) ? (mux ? 32 : 16) * W : 16;
                got = '0;
                st = 2;
                n = 0;
            end
        end else if (st == 2) begin
            got = {got[446:0], din};
            n = n + 1;
            if (n == len) begin
                hdr = {8'hE8, c, t + 10'(fault)};
                for (int i = 23; i >= 0; i--) q.push_back(hdr[i]);
                st = 3;
            end
        end else if (st == 3) begin
            if (strb) q.push_back(din);
            else st = 0;
        end
    end
    // The return clock runs only while bits are queued.
    always @(negedge rc) begin
        act <= (q.size() > 0);
        if (q.size() > 0) rdat <= q.pop_front();
        else rdat <= ~rdat;
    end
endmodule // cledh_drv_model

// File: testbench/cledh_host_tb.sv
module cledh_host_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int W = 14;
    logic         clock = 1'b0;
    logic         rst_n = 1'b0;
    logic         cyc   = 1'b0;
    logic         stb   = 1'b0;
    logic         we    = 1'b0;
    logic         fault = 1'b0;
    logic         mux   = 1'b0;
    logic [5:0]   adr   = 6'h00;
    logic [31:0]  dat   = 32'h00000000;
    logic [31:0]  rd, wb_dat_o;
    logic         wb_ack_o, sck, sdo, sfr, rck, rdt;
    logic [447:0] got;
    logic [5:0]   gcmd;
    logic [9:0]   gtal;
    int           err_count = 0;
    int           cmp_count = 0;
    always #12.5 clock = ~clock;
    cledh_host #(.PWM_W(W)) u_dut (.clock(clock), .rst_n(rst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .serial_clock_out(sck),
        .serial_data_out(sdo), .frame_strobe_out(sfr), .return_clock_in(rck),
        .return_data_in(rdt));
    cledh_drv_model #(.W(W)) u_drv (.lclk(sck), .din(sdo), .strb(sfr), .fault(fault),
        .mux(mux), .rclk(rck), .rdat(rdt), .got(got), .c(gcmd), .t(gtal));
    ////////////////////////////////////////////////////////////////////////////////
    task stop_test;
        $display("errors %0d compares %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task wb(input logic w, input logic [5:0] a, input logic [31:0] d);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        rd = wb_dat_o;
        if (n >= 20) begin
            err_count++;
            stop_test;
        end
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clock);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task run(input int c, input int m, input int f);
        int          n, nw, ww;
        logic [15:0] w;
        logic [31:0] e;
        mux <= 1'(m);
        fault <= 1'(f);
        nw = (c == 0) ? (m ? 32 : 16) : 1;
        ww = (c == 0) ? W : 16;
        wb(1'b1, 6'h10, 32'h0);
        for (int i = 0; i < nw; i++) wb(1'b1, 6'h14, 32'h3A5C + i * 32'h0713);
        wb(1'b1, 6'h04, 32'h8);
        wb(1'b1, 6'h08, 32'hA5);
        wb(1'b1, 6'h00, {16'h0, 8'h01, 4'h0, 1'(m), 2'(c), 1'b1});
        n = 0;
        do begin
            wb(1'b0, 6'h0C, 32'h0);
            n++;
        end while (rd[1] !== 1'b1 && n < 3000);
        if (n >= 3000) begin
            err_count++;
            stop_test;
        end
        chk(rd[25:16], f);
        chk(rd[13:8], {3{2'(c)}});
        chk(rd[2], 1'b1);
        chk(gcmd, {3{2'(c)}});
        chk(gtal, 10'h000);
        for (int i = 0; i < nw; i++) begin
            w = 16'h3A5C + 16'(i) * 16'h0713;
            e = (c == 0) ? w & ((32'h1 << W) - 1) : (c == 1) ? w : {w[7:0], w[7:0]};
            chk(32'(got >> ((nw - 1 - i) * ww)) & ((32'h1 << ww) - 1), e);
        end
    endtask
    initial begin
        repeat (19) @(posedge clock);
        chk({sck, sdo, sfr, wb_ack_o}, 32'h0);
        @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        wb(1'b0, 6'h00, 32'h0);
        chk(rd, 32'h100);
        wb(1'b0, 6'h3C, 32'h0);
        chk(rd, 32'h0);
        for (int c = 1; c < 4; c++) run(c, 0, c % 2);
        run(0, 0, 1);
        run(0, 1, 0);
        wb(1'b1, 6'h00, 32'h0000_FF09);
        wb(1'b0, 6'h0C, 32'h0);
        chk(rd[4:0], 32'h16);
        wb(1'b0, 6'h00, 32'h0);
        chk(rd, 32'hFF08);
        stop_test;
    end
endmodule // cledh_host_tb
